// ---- crma_pkg.sv ----
// Notes on behaviour
// - Write request: token 192, 24-bit return, 16-bit register, 32-bit data, token 1.
// - Write reply is tokens 3,1 on success or 4,1 on failure.
// - Read request: token 193, 24-bit return, 16-bit register, token 1.
// - Read reply is 3, 32-bit value, 1; failure gives tokens 4 then 1.
// - Peripheral read: token 37, return, 8-bit register, 8-bit size, token 1.
// - Reply goes to the endpoint named by the 24-bit return field.
// - Write with return low byte all ones is done but not answered if the bank reports no error.
// - Multi-byte fields travel most significant byte first.
package crma_pkg;

    // ========================================================================
    // Token codes.
    localparam logic [7:0] TOK_WRITE = 8'hc0;
    localparam logic [7:0] TOK_READ = 8'hc1;
    localparam logic [7:0] TOK_PREAD = 8'h25;
    localparam logic [7:0] TOK_END = 8'h01;
    localparam logic [7:0] TOK_ACK = 8'h03;
    localparam logic [7:0] TOK_NACK = 8'h04;
    localparam logic [7:0] NOREPLY_LOW = 8'hff;

    // ========================================================================
    // Field lengths in bytes.
    localparam logic [2:0] RET_BYTES = 3'h3;
    localparam logic [2:0] REG_BYTES = 3'h2;
    localparam logic [2:0] PREG_BYTES = 3'h2;
    localparam logic [2:0] DATA_BYTES = 3'h4;

    // ========================================================================
    // Target selection and request kinds.
    typedef enum logic [1:0] {CRMA_TILE, CRMA_NODE, CRMA_PERIPH} crma_target_t;
    typedef enum logic [1:0] {CRMA_OP_WR, CRMA_OP_RD, CRMA_OP_PRD, CRMA_OP_BAD} crma_op_t;

endpackage

// ---- crma_reg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Reply job from the parser towards the reply sender and out.
interface crma_reg_if;
    logic req;
    logic ok;
    logic is_read;
    logic [31:0] rdata;
    logic [23:0] ret_id;
    logic silent;
    logic busy;
    modport parser (output req, output ok, output is_read, output rdata, output ret_id,
        output silent, input busy);
    modport sender (input req, input ok, input is_read, input rdata, input ret_id,
        input silent, output busy);
endinterface
`default_nettype wire

// ---- crma_reply.sv ----
`timescale 1ns/1ps
`default_nettype none
// Serialises one reply: status token, optional data MSB first, closing token.
module crma_reply
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Reply job.
    crma_reg_if.sender job,
    // Byte stream out.
    output logic tx_valid_out,
    output logic tx_ctrl_out,
    output logic [7:0] tx_byte_out,
    output logic [23:0] tx_dest_out,
    input wire logic tx_ready_in
);
    typedef enum logic [1:0] {RS_IDLE, RS_STAT, RS_DATA, RS_END} crma_rs_t;
    crma_rs_t st_r;
    logic [31:0] sh_r;
    logic [2:0] cnt_r;
    logic ok_r;
    logic rd_r;

    assign job.busy = (st_r != RS_IDLE);

    // ========================================================================
    // Reply sequencer; each byte advances only when the interconnect takes it.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_r <= RS_IDLE;
            sh_r <= 32'h0;
            cnt_r <= 3'h0;
            ok_r <= 1'b0;
            rd_r <= 1'b0;
            tx_valid_out <= 1'b0;
            tx_ctrl_out <= 1'b0;
            tx_byte_out <= 8'h00;
            tx_dest_out <= 24'h0;
        end
        else if (ce_in)
        begin
            case (st_r)
                RS_IDLE:
                begin
                    if (job.req && !job.silent)
                    begin
                        st_r <= RS_STAT;
                        ok_r <= job.ok;
                        rd_r <= job.is_read;
                        sh_r <= job.rdata;
                        tx_dest_out <= job.ret_id;
                        tx_valid_out <= 1'b1;
                        tx_ctrl_out <= 1'b1;
                        tx_byte_out <= job.ok ? crma_pkg::TOK_ACK : crma_pkg::TOK_NACK;
                    end
                end
                RS_STAT:
                begin
                    if (tx_ready_in)
                    begin
                        if (ok_r && rd_r)
                        begin
                            st_r <= RS_DATA;
                            cnt_r <= crma_pkg::DATA_BYTES - 3'h1;
                            tx_ctrl_out <= 1'b0;
                            tx_byte_out <= sh_r[31:24];
                            sh_r <= {sh_r[23:0], 8'h00};
                        end
                        else
                        begin
                            st_r <= RS_END;
                            tx_byte_out <= crma_pkg::TOK_END;
                        end
                    end
                end
                RS_DATA:
                begin
                    if (tx_ready_in)
                    begin
                        if (cnt_r == 3'h0)
                        begin
                            st_r <= RS_END;
                            tx_ctrl_out <= 1'b1;
                            tx_byte_out <= crma_pkg::TOK_END;
                        end
                        else
                        begin
                            cnt_r <= cnt_r - 3'h1;
                            tx_byte_out <= sh_r[31:24];
                            sh_r <= {sh_r[23:0], 8'h00};
                        end
                    end
                end
                RS_END:
                begin
                    if (tx_ready_in)
                    begin
                        st_r <= RS_IDLE;
                        tx_valid_out <= 1'b0;
                        tx_ctrl_out <= 1'b0;
                    end
                end
                default:
                begin
                    st_r <= RS_IDLE;
                    tx_valid_out <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- crma_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Message-driven configuration register access port for one target.
module crma_top
#(
    parameter crma_pkg::crma_target_t TARGET = crma_pkg::CRMA_TILE
)
(
    // Clock, reset, enable.
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Request byte stream.
    input wire logic rx_valid_in,
    input wire logic rx_ctrl_in,
    input wire logic [7:0] rx_byte_in,
    output logic rx_ready_out,
    // Reply byte stream.
    output logic tx_valid_out,
    output logic tx_ctrl_out,
    output logic [7:0] tx_byte_out,
    output logic [23:0] tx_dest_out,
    input wire logic tx_ready_in,
    // Register bank port.
    output logic reg_we_out,
    output logic reg_re_out,
    output logic [15:0] reg_addr_out,
    output logic [31:0] reg_wdata_out,
    output logic [7:0] reg_size_out,
    input wire logic [31:0] reg_rdata_in,
    input wire logic reg_err_in
);
    typedef enum logic [2:0] {PS_OPEN, PS_RET, PS_REG, PS_DATA, PS_CLOSE, PS_DRAIN,
        PS_EXEC, PS_WAIT} crma_ps_t;

    crma_reg_if job ();
    crma_ps_t st_r;
    crma_pkg::crma_op_t op_r;
    logic [2:0] cnt_r;
    logic [23:0] ret_r;
    logic [15:0] addr_r;
    logic [31:0] data_r;
    logic fail_r;
    logic req_r;
    logic ok_r;
    logic pend_r;
    logic take;

    // Requests stall at the interconnect while a reply is still pending.
    assign take = rx_valid_in && rx_ready_out;

    // ========================================================================
    // Request parser. A bank access result arrives one cycle after the strobe.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_r <= PS_OPEN;
            op_r <= crma_pkg::CRMA_OP_BAD;
            cnt_r <= 3'h0;
            ret_r <= 24'h0;
            addr_r <= 16'h0;
            data_r <= 32'h0;
            fail_r <= 1'b0;
            rx_ready_out <= 1'b0;
            reg_we_out <= 1'b0;
            reg_re_out <= 1'b0;
            reg_addr_out <= 16'h0;
            reg_wdata_out <= 32'h0;
            reg_size_out <= 8'h00;
        end
        else if (ce_in)
        begin
            reg_we_out <= 1'b0;
            reg_re_out <= 1'b0;
            case (st_r)
                PS_OPEN:
                begin
                    rx_ready_out <= 1'b1;
                    cnt_r <= crma_pkg::RET_BYTES;
                    fail_r <= 1'b0;
                    if (take && rx_ctrl_in)
                    begin
                        st_r <= PS_RET;
                        if (rx_byte_in == crma_pkg::TOK_WRITE && TARGET != crma_pkg::CRMA_PERIPH)
                            op_r <= crma_pkg::CRMA_OP_WR;
                        else if (rx_byte_in == crma_pkg::TOK_READ
                            && TARGET != crma_pkg::CRMA_PERIPH)
                            op_r <= crma_pkg::CRMA_OP_RD;
                        else if (rx_byte_in == crma_pkg::TOK_PREAD
                            && TARGET == crma_pkg::CRMA_PERIPH)
                            op_r <= crma_pkg::CRMA_OP_PRD;
                        else
                            op_r <= crma_pkg::CRMA_OP_BAD;
                    end
                end
                PS_RET, PS_REG, PS_DATA:
                begin
                    if (take && rx_ctrl_in)
                    begin
                        // Truncated: a control token inside a data field.
                        fail_r <= 1'b1;
                        st_r <= (rx_byte_in == crma_pkg::TOK_END) ? PS_EXEC : PS_DRAIN;
                        rx_ready_out <= (rx_byte_in != crma_pkg::TOK_END);
                    end
                    else if (take)
                    begin
                        if (st_r == PS_RET)
                            ret_r <= {ret_r[15:0], rx_byte_in};
                        else if (st_r == PS_REG)
                            addr_r <= {addr_r[7:0], rx_byte_in};
                        else
                            data_r <= {data_r[23:0], rx_byte_in};
                        cnt_r <= cnt_r - 3'h1;
                        if (cnt_r == 3'h1)
                        begin
                            if (st_r == PS_RET)
                            begin
                                st_r <= PS_REG;
                                cnt_r <= (op_r == crma_pkg::CRMA_OP_PRD)
                                    ? crma_pkg::PREG_BYTES : crma_pkg::REG_BYTES;
                            end
                            else if (st_r == PS_REG && op_r == crma_pkg::CRMA_OP_WR)
                            begin
                                st_r <= PS_DATA;
                                cnt_r <= crma_pkg::DATA_BYTES;
                            end
                            else
                                st_r <= PS_CLOSE;
                        end
                    end
                end
                PS_CLOSE:
                begin
                    if (take)
                    begin
                        // Only the closing token lets the request act.
                        if (!(rx_ctrl_in && rx_byte_in == crma_pkg::TOK_END))
                            fail_r <= 1'b1;
                        if (rx_ctrl_in && rx_byte_in == crma_pkg::TOK_END)
                        begin
                            st_r <= PS_EXEC;
                            rx_ready_out <= 1'b0;
                        end
                        else
                            st_r <= PS_DRAIN;
                    end
                end
                PS_DRAIN:
                begin
                    // Discard the rest of a bad message up to its closing token.
                    if (take && rx_ctrl_in && rx_byte_in == crma_pkg::TOK_END)
                    begin
                        st_r <= PS_EXEC;
                        rx_ready_out <= 1'b0;
                    end
                end
                PS_EXEC:
                begin
                    rx_ready_out <= 1'b0;
                    st_r <= PS_WAIT;
                    if (!fail_r && op_r != crma_pkg::CRMA_OP_BAD)
                    begin
                        reg_addr_out <= (op_r == crma_pkg::CRMA_OP_PRD)
                            ? {8'h00, addr_r[15:8]} : addr_r;
                        reg_size_out <= (op_r == crma_pkg::CRMA_OP_PRD) ? addr_r[7:0] : 8'h00;
                        reg_wdata_out <= data_r;
                        reg_we_out <= (op_r == crma_pkg::CRMA_OP_WR);
                        reg_re_out <= (op_r != crma_pkg::CRMA_OP_WR);
                    end
                end
                PS_WAIT:
                begin
                    // Hold off the next request until the reply has gone out.
                    if (!pend_r && !req_r && !job.busy)
                        st_r <= PS_OPEN;
                end
                default:
                    st_r <= PS_OPEN;
            endcase
        end
    end

    // ========================================================================
    // Reply job is raised one cycle after the bank strobe, when its result is valid.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pend_r <= 1'b0;
            req_r <= 1'b0;
            ok_r <= 1'b0;
        end
        else if (ce_in)
        begin
            // The strobe cycle itself carries no result yet, so the job waits one more cycle.
            pend_r <= (st_r == PS_EXEC);
            req_r <= pend_r;
            ok_r <= !fail_r && op_r != crma_pkg::CRMA_OP_BAD;
        end
    end

    assign job.req = req_r;
    assign job.ok = ok_r && !reg_err_in;
    assign job.is_read = (op_r != crma_pkg::CRMA_OP_WR);
    assign job.rdata = reg_rdata_in;
    assign job.ret_id = ret_r;
    // Failed writes still answer so the requester learns of the failure.
    assign job.silent = (op_r == crma_pkg::CRMA_OP_WR) && ok_r && !reg_err_in
        && (ret_r[7:0] == crma_pkg::NOREPLY_LOW);

    crma_reply u_reply
    (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .job(job.sender),
        .tx_valid_out(tx_valid_out),
        .tx_ctrl_out(tx_ctrl_out),
        .tx_byte_out(tx_byte_out),
        .tx_dest_out(tx_dest_out),
        .tx_ready_in(tx_ready_in)
    );
endmodule
`default_nettype wire

// ---- crma_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port-level checks of the register message port.
module crma_sva
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Request stream.
    input wire logic ce_in,
    input wire logic rx_valid_in,
    input wire logic rx_ctrl_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_ready_out,
    // Reply stream.
    input wire logic tx_valid_out,
    input wire logic tx_ctrl_out,
    input wire logic [7:0] tx_byte_out,
    input wire logic [23:0] tx_dest_out,
    input wire logic tx_ready_in,
    // Register bank.
    input wire logic reg_we_out,
    input wire logic reg_re_out,
    input wire logic reg_err_in
);
    // All checks share the one clock and its reset.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic close_tk;
    logic strobe;
    // Closing token taken, and either bank strobe.
    assign close_tk = ce_in && rx_valid_in && rx_ready_out && rx_ctrl_in && rx_byte_in == 8'h01;
    assign strobe = reg_we_out || reg_re_out;
    chk_close_drops: assert property (close_tk |=> !rx_ready_out)
        else $error("request port open after closing token");
    chk_strobe_closed: assert property (strobe |-> !rx_ready_out)
        else $error("bank strobe while request still open");
    chk_strobe_pulse: assert property (strobe |=> !strobe)
        else $error("bank strobe longer than one cycle");
    chk_status_first: assert property ($rose(tx_valid_out) |-> tx_ctrl_out &&
        (tx_byte_out == crma_pkg::TOK_ACK || tx_byte_out == crma_pkg::TOK_NACK))
        else $error("reply does not open with a status token");
    chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out &&
        $stable(tx_byte_out) && $stable(tx_ctrl_out) && $stable(tx_dest_out))
        else $error("reply byte changed while stalled");
    chk_err_nack: assert property (strobe ##1 reg_err_in |-> ##[0:1]
        (tx_valid_out && tx_ctrl_out && tx_byte_out == crma_pkg::TOK_NACK))
        else $error("bank failure not answered with failure token");
    chk_read_ack: assert property (reg_re_out ##1 !reg_err_in |-> ##[0:1]
        (tx_valid_out && tx_ctrl_out && tx_byte_out == crma_pkg::TOK_ACK))
        else $error("good read not answered with success token");
    chk_ready_back: assert property ($fell(tx_valid_out) |-> ##[1:3] rx_ready_out)
        else $error("request port not reopened after reply");
endmodule
bind crma_top crma_sva crma_sva_inst
(
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .rx_valid_in(rx_valid_in),
    .rx_ctrl_in(rx_ctrl_in),
    .rx_byte_in(rx_byte_in),
    .rx_ready_out(rx_ready_out),
    .tx_valid_out(tx_valid_out),
    .tx_ctrl_out(tx_ctrl_out),
    .tx_byte_out(tx_byte_out),
    .tx_dest_out(tx_dest_out),
    .tx_ready_in(tx_ready_in),
    .reg_we_out(reg_we_out),
    .reg_re_out(reg_re_out),
    .reg_err_in(reg_err_in)
);
`default_nettype wire

// ---- crma_req_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====================
// Requesting endpoint: takes reply bytes and logs them.
module crma_req_model
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // High makes the endpoint stall every other cycle.
    input wire logic slow_in,
    // Reply stream from the port.
    input wire logic tx_valid_in,
    input wire logic tx_ctrl_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic [23:0] tx_dest_in,
    output logic tx_ready_out
);
    logic [32:0] got_q[$];
    logic phase_r;
    // Alternating stall, so a held reply byte is really tested.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            phase_r <= 1'h0;
        else
            phase_r <= !phase_r;
    end
    assign tx_ready_out = !slow_in || phase_r;
    // Each taken byte is logged with its destination and token flag.
    always @(posedge clk_in)
    begin
        if (rst_n_in && tx_valid_in && tx_ready_out)
            got_q.push_back({tx_dest_in, tx_ctrl_in, tx_byte_in});
    end
endmodule
`default_nettype wire

// ---- test_crma_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
// ====================
// Self-checking bench of the register message port, tile and peripheral targets.
module test_crma_top;
    typedef struct packed {logic [7:0] op; logic [23:0] ret; logic [15:0] rg; logic [31:0] d;
        logic [31:0] rd; logic err; logic [3:0] cut;} crma_row_t;
    logic clk_in = 1'h0;
    logic rst_n_in, ce_in, rx_valid_in, rx_ctrl_in, rx_ready_out, tx_valid_out, tx_ctrl_out;
    logic tx_ready_in, reg_we_out, reg_re_out, reg_err_in, slow;
    logic [7:0] rx_byte_in, tx_byte_out;
    logic [23:0] tx_dest_out;
    logic [15:0] reg_addr_out;
    logic [31:0] reg_wdata_out, reg_rdata_in;
    logic [49:0] acc;
    logic sel_p, p_rdy, p_txv, p_txc, p_we, p_re;
    logic [7:0] p_txb, p_size;
    logic [15:0] p_addr;
    logic [23:0] p_dest;
    wire logic rdy;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // Cut is the count of field bytes sent before the closing token; f means all.
    crma_row_t rows [9] = '{
        '{8'hc0, 24'h123456, 16'h0002, 32'hdeadbeef, 32'h0, 1'h0, 4'hf},
        '{8'hc0, 24'h00a1b2, 16'h8001, 32'h01020304, 32'h0, 1'h1, 4'hf},
        '{8'hc1, 24'h654321, 16'h000c, 32'h0, 32'h0a0b0c0d, 1'h0, 4'hf},
        '{8'hc1, 24'h0f0e0d, 16'hffff, 32'h0, 32'h80000001, 1'h1, 4'hf},
        '{8'hc0, 24'h4321ff, 16'h0005, 32'hcafef00d, 32'h0, 1'h0, 4'hf},
        '{8'hc0, 24'h0001ff, 16'h0006, 32'h3, 32'h0, 1'h1, 4'hf},
        '{8'h25, 24'h777777, 16'h0001, 32'h0, 32'h12345678, 1'h0, 4'hf},
        '{8'hc1, 24'h111111, 16'h0003, 32'h0, 32'h5, 1'h0, 4'h1},
        '{8'hc0, 24'h222222, 16'h0004, 32'h9, 32'h0, 1'h0, 4'h5}};
    // The clock toggles every 20 ns, a period of 40 ns.
    always #20 clk_in = !clk_in;
    // Ready of whichever target the request lines are aimed at.
    assign rdy = sel_p ? p_rdy : rx_ready_out;
    // Tile target; the peripheral target below takes the request lines while sel_p is high.
    crma_top #(.TARGET(crma_pkg::CRMA_TILE)) crma_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ce_in(ce_in), .rx_valid_in(rx_valid_in && !sel_p), .rx_ctrl_in(rx_ctrl_in),
        .rx_byte_in(rx_byte_in), .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out),
        .tx_ctrl_out(tx_ctrl_out), .tx_byte_out(tx_byte_out), .tx_dest_out(tx_dest_out),
        .tx_ready_in(tx_ready_in), .reg_we_out(reg_we_out), .reg_re_out(reg_re_out),
        .reg_addr_out(reg_addr_out), .reg_wdata_out(reg_wdata_out), .reg_size_out(),
        .reg_rdata_in(reg_rdata_in), .reg_err_in(reg_err_in));
    if (1)
    begin : g_periph
        crma_top #(.TARGET(crma_pkg::CRMA_PERIPH)) crma_top_inst (.clk_in(clk_in),
            .rst_n_in(rst_n_in), .ce_in(ce_in), .rx_valid_in(rx_valid_in && sel_p),
            .rx_ctrl_in(rx_ctrl_in), .rx_byte_in(rx_byte_in), .rx_ready_out(p_rdy),
            .tx_valid_out(p_txv), .tx_ctrl_out(p_txc), .tx_byte_out(p_txb), .tx_dest_out(p_dest),
            .tx_ready_in(tx_ready_in), .reg_we_out(p_we), .reg_re_out(p_re), .reg_addr_out(p_addr),
            .reg_wdata_out(), .reg_size_out(p_size), .reg_rdata_in(reg_rdata_in),
            .reg_err_in(reg_err_in));
    end
    crma_req_model crma_req_model_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
        .tx_valid_in(sel_p ? p_txv : tx_valid_out), .tx_ctrl_in(sel_p ? p_txc : tx_ctrl_out),
        .tx_byte_in(sel_p ? p_txb : tx_byte_out), .tx_dest_in(sel_p ? p_dest : tx_dest_out),
        .tx_ready_out(tx_ready_in));
    // Last bank access, kept so each row can see what reached the bank.
    always @(posedge clk_in)
    begin
        if (reg_we_out || reg_re_out)
            acc <= {reg_we_out, reg_re_out, reg_addr_out, reg_wdata_out};
        else if (p_we || p_re)
            acc <= {p_we, p_re, p_addr, 24'h0, p_size};
    end
    // A hang is cut short well past the few hundred cycles the run needs.
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Offers one byte and holds it until the edge at which ready is high.
    task automatic put(input logic c, input logic [7:0] b);
        int w = 0;
        rx_valid_in <= 1'h1;
        rx_ctrl_in <= c;
        rx_byte_in <= b;
        @(negedge clk_in);
        while (rdy !== 1'h1 && w < 100)
        begin
            w++;
            @(negedge clk_in);
        end
        if (w == 100)
            n_errors++;
        @(posedge clk_in);
    endtask
    // Sends one request, fields most significant byte first, and checks the outcome.
    task automatic run_row(input crma_row_t r);
        logic [32:0] exp_q[$];
        logic [71:0] f = {r.ret, r.rg, r.d};
        logic wr = r.op == crma_pkg::TOK_WRITE;
        logic full = r.cut == 4'hf
            && (sel_p ? r.op == crma_pkg::TOK_PREAD : wr || r.op == crma_pkg::TOK_READ);
        logic ok = full && !r.err;
        logic [15:0] ea = !full ? 16'h0 : sel_p ? {8'h00, r.rg[15:8]} : r.rg;
        logic [32:0] gb;
        int w = 0;
        if (!(wr && ok && r.ret[7:0] == crma_pkg::NOREPLY_LOW))
        begin
            exp_q.push_back({r.ret, 1'h1, ok ? crma_pkg::TOK_ACK : crma_pkg::TOK_NACK});
            for (int i = 3; i >= 0 && ok && !wr; i--)
                exp_q.push_back({r.ret, 1'h0, r.rd[8*i +: 8]});
            exp_q.push_back({r.ret, 1'h1, crma_pkg::TOK_END});
        end
        reg_rdata_in <= r.rd;
        reg_err_in <= r.err;
        acc = '0;
        crma_req_model_inst.got_q.delete();
        put(1'h1, r.op);
        for (int i = 0; i < (wr ? 9 : 5) && i < r.cut; i++)
            put(1'h0, f[71 - 8*i -: 8]);
        put(1'h1, crma_pkg::TOK_END);
        rx_valid_in <= 1'h0;
        rx_byte_in <= ~rx_byte_in;
        @(negedge clk_in);
        while (!(crma_req_model_inst.got_q.size() == exp_q.size() && rdy === 1'h1)
            && w < 200)
        begin
            w++;
            @(negedge clk_in);
        end
        if (w == 200)
            n_errors++;
        @(posedge clk_in);
        `CHK("reply count", exp_q.size(), crma_req_model_inst.got_q.size())
        // A return field cut short leaves bytes of the previous request in the destination, so only then is it masked.
        foreach (exp_q[i])
        begin
            gb = crma_req_model_inst.got_q[i];
            `CHK("reply byte", exp_q[i], r.cut >= 4'h3 ? gb : {r.ret, gb[8:0]})
        end
        `CHK("bank access", {wr && full, !wr && full, ea}, acc[49:32])
        if (wr && full)
            `CHK("write data", r.d, acc[31:0])
        if (sel_p && full)
            `CHK("bank size", r.rg[7:0], acc[7:0])
    endtask
    // Tile ready, reply valid and bank strobe must be quiet while reset is held.
    task automatic rst_chk();
        @(negedge clk_in);
        `CHK("ready in reset", 1'h0, rx_ready_out)
        `CHK("reply in reset", 1'h0, tx_valid_out)
        `CHK("strobe in reset", 1'h0, reg_we_out || reg_re_out)
        @(posedge clk_in);
    endtask
    // Main sequence: reset, table rows, then a reset in mid-request.
    initial
    begin
        rst_n_in = 1'h0;
        ce_in = 1'h1;
        rx_valid_in = 1'h0;
        rx_ctrl_in = 1'h0;
        rx_byte_in = 8'h0;
        reg_rdata_in = 32'h0;
        reg_err_in = 1'h0;
        slow = 1'h0;
        sel_p = 1'h0;
        repeat (10) @(posedge clk_in);
        rst_chk();
        rst_n_in <= 1'h1;
        repeat (2) @(posedge clk_in);
        foreach (rows[i])
        begin
            slow <= i[0];
            run_row(rows[i]);
        end
        // Peripheral target: a good register-and-size read, then a bank opcode it refuses.
        sel_p <= 1'h1;
        @(posedge clk_in);
        run_row(rows[6]);
        run_row(rows[2]);
        sel_p <= 1'h0;
        @(posedge clk_in);
        put(1'h1, crma_pkg::TOK_WRITE);
        put(1'h0, 8'h12);
        rst_n_in <= 1'h0;
        rx_valid_in <= 1'h0;
        rst_chk();
        // Released with the enable low, the port must stay frozen in its reset state.
        ce_in <= 1'h0;
        rst_n_in <= 1'h1;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        `CHK("ready frozen", 1'h0, rx_ready_out)
        @(posedge clk_in);
        ce_in <= 1'h1;
        repeat (2) @(posedge clk_in);
        run_row(rows[2]);
        finish_test();
    end
endmodule
`default_nettype wire
